/* ssc_seq_ctrl.sv */
// Start/stop control of one sequence channel.
// Assumes a serial byte engine that emits START, runs the stored sequence
// and reports bytes and STOP; a host on the plain register port.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_seq_ctrl #(
  parameter int TICK_CYC = `SSC_TICK_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [7:0]            regRdata,
  input  wire logic                  trigPin,
  input  wire ssc_pkg::ssc_eng_sts_t engSts,
  output ssc_pkg::ssc_eng_cmd_t      engCmd,
  output logic                       irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ssc_pkg::ssc_state_t state;
  ssc_pkg::ssc_state_t next_state;
  logic [7:0]          frame_repeat_count;
  logic [7:0]          refresh_interval;
  logic [7:0]          intMask;
  logic [7:0]          byteCount;
  logic [7:0]          byteRun;
  logic [7:0]          framesLeft;
  logic [7:0]          tickCnt;
  logic [7:0]          ticksDone;
  logic                tick;
  logic                timerDue;
  logic                seqDone;
  logic                loopDone;
  logic                startBit;
  logic                trigMode;
  logic                fldOnStop;
  logic                endAfterFrame;
  logic                trigEdge;
  logic                wrCtrl;
  logic                rdStatus;
  logic                stopNow;
  logic                stopSeq;
  logic                launch;
  logic                frameGo;
  logic                stopIssue;
  logic                setSd;
  logic                setFld;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction

  ssc_trig_sync uTrig (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .trigPin  (trigPin),
    .trigEdge (trigEdge)
  );

  // ****************************************************************
  // Write and status-read decode
  // ****************************************************************
  assign wrCtrl   = regWr && hit(regAddr, `SSC_ADDR_CTRL);
  assign rdStatus = regRd && hit(regAddr, `SSC_ADDR_STATUS);
  // Stop bits count only while the start bit stands
  assign stopNow  = wrCtrl && startBit && regWdata[`SSC_CTRL_STOPNOW];
  // Immediate stop masks stop-after-frame in the same write
  assign stopSeq  = wrCtrl && startBit && !regWdata[`SSC_CTRL_STOPNOW]
                    && regWdata[`SSC_CTRL_STOPSEQ];
  // Start is only heard while idle
  assign launch   = wrCtrl && (state == ssc_pkg::SSC_IDLE)
                    && regWdata[`SSC_CTRL_START];

  // ****************************************************************
  // Sequence state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    frameGo    = 1'b0;
    stopIssue  = 1'b0;
    setSd      = 1'b0;
    setFld     = 1'b0;
    unique case (state)
      ssc_pkg::SSC_IDLE: begin
        if (launch) begin
          if (regWdata[`SSC_CTRL_TRIGEN]) begin
            next_state = ssc_pkg::SSC_LOOPIDLE;
          end else if (frame_repeat_count == 8'h01) begin
            next_state = ssc_pkg::SSC_ACTIVE;
            frameGo    = 1'b1;
          end else begin
            next_state = ssc_pkg::SSC_LOOPACT;
            frameGo    = 1'b1;
          end
        end
      end
      ssc_pkg::SSC_ACTIVE: begin
        if (stopNow) begin
          next_state = ssc_pkg::SSC_STOPPING;
          stopIssue  = 1'b1;
        end else if (engSts.stopDone) begin
          next_state = ssc_pkg::SSC_IDLE;
          setSd      = 1'b1;
        end
      end
      ssc_pkg::SSC_STOPPING: begin
        if (engSts.stopDone) begin
          next_state = ssc_pkg::SSC_IDLE;
          setSd      = 1'b1;
          setFld     = fldOnStop;
        end
      end
      ssc_pkg::SSC_LOOPIDLE: begin
        if (stopNow || stopSeq) begin
          // Nothing on the wire between frames, so stop at once
          next_state = ssc_pkg::SSC_IDLE;
          setSd      = 1'b1;
          setFld     = 1'b1;
        end else if (trigMode ? trigEdge : timerDue) begin
          next_state = ssc_pkg::SSC_LOOPACT;
          frameGo    = 1'b1;
        end
      end
      ssc_pkg::SSC_LOOPACT: begin
        if (trigMode && (stopNow || stopSeq)) begin
          next_state = ssc_pkg::SSC_IDLE;
          stopIssue  = 1'b1;
          setSd      = 1'b1;
          setFld     = 1'b1;
        end else if (stopNow) begin
          next_state = ssc_pkg::SSC_STOPPING;
          stopIssue  = 1'b1;
        end else if (engSts.stopDone) begin
          if (endAfterFrame || (!trigMode && framesLeft == 8'h01)) begin
            next_state = ssc_pkg::SSC_IDLE;
            setSd      = 1'b1;
            setFld     = 1'b1;
          end else begin
            next_state = ssc_pkg::SSC_LOOPIDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ssc_pkg::SSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Loop bookkeeping
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      startBit      <= 1'b0;
      trigMode      <= 1'b0;
      fldOnStop     <= 1'b0;
      endAfterFrame <= 1'b0;
      framesLeft    <= 8'h00;
    end else begin
      if (launch) begin
        startBit      <= 1'b1;
        trigMode      <= regWdata[`SSC_CTRL_TRIGEN];
        endAfterFrame <= 1'b0;
        framesLeft    <= frame_repeat_count;
      end else if (next_state == ssc_pkg::SSC_IDLE) begin
        startBit <= 1'b0;
      end
      if (stopIssue) begin
        fldOnStop <= (state == ssc_pkg::SSC_LOOPACT);
      end
      if (stopSeq && state == ssc_pkg::SSC_LOOPACT && !trigMode) begin
        endAfterFrame <= 1'b1;
      end
      // A count of zero loops until stopped
      if (engSts.stopDone && state == ssc_pkg::SSC_LOOPACT
          && framesLeft != 8'h00) begin
        framesLeft <= framesLeft - 8'h01;
      end
    end
  end

  // ****************************************************************
  // Interval timer, one tick per microsecond
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tickCnt <= 8'h00;
      tick    <= 1'b0;
    end else begin
      tick    <= (tickCnt == 8'(TICK_CYC - 1));
      tickCnt <= (tickCnt == 8'(TICK_CYC - 1)) ? 8'h00 : tickCnt + 8'h01;
    end
  end

  // Period runs from each frame's START; a late frame starts on finish
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ticksDone <= 8'h00;
      timerDue  <= 1'b0;
    end else if (frameGo) begin
      ticksDone <= 8'h00;
      timerDue  <= 1'b0;
    end else if (tick && !timerDue) begin
      ticksDone <= ticksDone + 8'h01;
      timerDue  <= (ticksDone + 8'h01 >= refresh_interval);
    end
  end

  // ****************************************************************
  // Engine commands and byte count
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      engCmd <= '0;
    end else begin
      engCmd.start <= frameGo;
      if (stopIssue) begin
        engCmd.stopReq <= 1'b1;
      end else if (engSts.stopDone) begin
        engCmd.stopReq <= 1'b0;
      end
      // Read in flight: take one more byte and answer it with NACK
      engCmd.nackNext <= (stopIssue || engCmd.stopReq) && engSts.rdXfer
                         && !engSts.stopDone;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      byteRun   <= 8'h00;
      byteCount <= 8'h00;
    end else begin
      if (frameGo) begin
        byteRun <= 8'h00;
      end else if (engSts.byteDone) begin
        byteRun <= byteRun + 8'h01;
      end
      if (engSts.stopDone) begin
        byteCount <= byteRun + {7'h00, engSts.byteDone};
      end
    end
  end

  // ****************************************************************
  // Registers, status and interrupt
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_repeat_count <= `SSC_RST_FRAME_REPEAT_COUNT;
      refresh_interval  <= `SSC_RST_REFRESH_INTERVAL;
      intMask  <= `SSC_RST_INTMASK;
    end else if (regWr) begin
      if (hit(regAddr, `SSC_ADDR_FRAME_REPEAT_COUNT) && !startBit) begin
        frame_repeat_count <= regWdata;
      end
      if (hit(regAddr, `SSC_ADDR_REFRESH_INTERVAL)) begin
        refresh_interval <= regWdata;
      end
      if (hit(regAddr, `SSC_ADDR_INTMASK)) begin
        intMask <= regWdata;
      end
    end
  end

  // A set in the clearing cycle wins over the read clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seqDone  <= 1'b0;
      loopDone <= 1'b0;
    end else begin
      seqDone  <= setSd || (seqDone && !rdStatus);
      loopDone <= setFld || (loopDone && !rdStatus);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq      <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      irq <= (seqDone && intMask[`SSC_STAT_SEQDONE])
             || (loopDone && intMask[`SSC_STAT_LOOPDONE]);
      regRdata <= 8'h00;
      if (regRd) begin
        unique case (regAddr)
          `SSC_ADDR_CTRL: begin
            regRdata[`SSC_CTRL_START]  <= startBit;
            regRdata[`SSC_CTRL_TRIGEN] <= trigMode;
            regRdata[`SSC_CTRL_ACTIVE] <= (state != ssc_pkg::SSC_IDLE);
          end
          `SSC_ADDR_FRAME_REPEAT_COUNT: regRdata <= frame_repeat_count;
          `SSC_ADDR_REFRESH_INTERVAL:  regRdata <= refresh_interval;
          `SSC_ADDR_STATUS: begin
            regRdata[`SSC_STAT_SEQDONE]  <= seqDone;
            regRdata[`SSC_STAT_LOOPDONE] <= loopDone;
          end
          `SSC_ADDR_INTMASK:  regRdata <= intMask;
          `SSC_ADDR_TRANSFERRED_BYTE_COUNT:  regRdata <= byteCount;
          default:            regRdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cbChk @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence sqSingleLaunch;
    launch && !regWdata[`SSC_CTRL_TRIGEN] && frame_repeat_count == 8'h01;
  endsequence

  // State and start pulse come from the same edge as the launch
  sequence sqStartPulse;
    engCmd.start ##1 !engCmd.start;
  endsequence

  AST_SINGLE_SHOT: assert property (
    sqSingleLaunch |=> state == ssc_pkg::SSC_ACTIVE ##0 sqStartPulse)
    else $error("Single shot start did not launch a frame");

  AST_NO_RESTART: assert property (
    state != ssc_pkg::SSC_IDLE && !stopNow && !stopSeq && !engSts.stopDone
    && !trigEdge && !timerDue |=> !engCmd.start)
    else $error("Frame launched while channel was already active");

  AST_READ_NACK: assert property (
    engCmd.stopReq && engSts.rdXfer && !engSts.stopDone |=> engCmd.nackNext)
    else $error("Read stop did not request NACK");

  AST_STOP_HELD: assert property (
    stopIssue |=> engCmd.stopReq throughout (!engSts.stopDone [*1]))
    else $error("Stop request not raised");

  AST_STOP_PRIORITY: assert property (
    wrCtrl && startBit && regWdata[`SSC_CTRL_STOPNOW] |-> !stopSeq && stopNow)
    else $error("Stop-after-frame won over immediate stop");

  AST_SINGLE_SD_ONLY: assert property (
    state == ssc_pkg::SSC_STOPPING && engSts.stopDone && !fldOnStop
    && !loopDone |=> seqDone && !loopDone)
    else $error("Single shot stop set the loop flag");

  AST_LOOP_STOP_FLAGS: assert property (
    state == ssc_pkg::SSC_LOOPIDLE && (stopNow || stopSeq)
    |=> state == ssc_pkg::SSC_IDLE && seqDone && loopDone)
    else $error("Loop idle stop did not end at once with both flags");

  AST_TRIG_IGNORED: assert property (
    state == ssc_pkg::SSC_LOOPIDLE && !trigMode && !timerDue
    && !stopNow && !stopSeq |=> state == ssc_pkg::SSC_LOOPIDLE)
    else $error("Timer loop left idle before its period");

  AST_STOP_NEEDS_START: assert property (
    state == ssc_pkg::SSC_IDLE && !launch |=> state == ssc_pkg::SSC_IDLE)
    else $error("Idle channel moved without a start");

endmodule
`default_nettype wire

/* ssc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// sequence start/stop control block.
// Assumes a 4-bit register address and 8-bit register data.
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SSC_ADDR_CTRL     4'h0
`define SSC_ADDR_FRAME_REPEAT_COUNT 4'h1
`define SSC_ADDR_REFRESH_INTERVAL  4'h2
`define SSC_ADDR_STATUS   4'h3
`define SSC_ADDR_INTMASK  4'h4
`define SSC_ADDR_TRANSFERRED_BYTE_COUNT  4'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define SSC_CTRL_START    7
`define SSC_CTRL_STOPNOW  6
`define SSC_CTRL_STOPSEQ  5
`define SSC_CTRL_TRIGEN   3
`define SSC_CTRL_ACTIVE   0
`define SSC_STAT_SEQDONE  7
`define SSC_STAT_LOOPDONE 6

// ****************************************************************
// Reset values
// ****************************************************************
`define SSC_RST_FRAME_REPEAT_COUNT  8'h01
`define SSC_RST_REFRESH_INTERVAL   8'h10
`define SSC_RST_INTMASK   8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SSC_CLK_NS        10
`define SSC_TICK_NS       1000
`define SSC_TICK_CYC      (`SSC_TICK_NS / `SSC_CLK_NS)

`endif

/* ssc_pkg.sv */
// Types shared by the sequence start/stop control block.
// Assumes nothing of its surroundings.
package ssc_pkg;

  typedef enum logic [2:0] {
    SSC_IDLE     = 3'b000,
    SSC_ACTIVE   = 3'b001,
    SSC_STOPPING = 3'b011,
    SSC_LOOPIDLE = 3'b010,
    SSC_LOOPACT  = 3'b110
  } ssc_state_t;

  // Commands to the serial byte engine
  typedef struct packed {
    logic start;
    logic stopReq;
    logic nackNext;
  } ssc_eng_cmd_t;

  // Reports from the serial byte engine
  typedef struct packed {
    logic byteDone;
    logic rdXfer;
    logic stopDone;
  } ssc_eng_sts_t;

endpackage

/* ssc_trig_sync.sv */
// Three-stage synchroniser and edge finder for the trigger pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ssc_trig_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic trigPin,
  output logic      trigEdge
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  // A change counts only once the second and third stages agree, so a
  // one-cycle glitch that never settles yields no edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1   <= 1'b0;
      stage2   <= 1'b0;
      stage3   <= 1'b0;
      level    <= 1'b0;
      trigEdge <= 1'b0;
    end else begin
      stage1   <= trigPin;
      stage2   <= stage1;
      stage3   <= stage2;
      trigEdge <= stage2 & stage3 & ~level;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end
endmodule
`default_nettype wire

/* ssc_eng_model.sv */
// Behavioural serial byte engine facing the sequence start/stop control.
// Assumes one clock, engCmd registered by the controller, and a bench that
// picks the direction of the transaction and the byte pace.
`timescale 1ns/1ps
`default_nettype none
module ssc_eng_model #(
  parameter int FRAME_BYTES = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire ssc_pkg::ssc_eng_cmd_t engCmd,
  input  wire logic                  rdMode,
  input  wire logic                  slow,
  output ssc_pkg::ssc_eng_sts_t      engSts
);
  logic       busy;
  logic [3:0] gap;
  logic [3:0] bytes;

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  // A stop request ends the frame at the byte in flight, so a read sees
  // exactly one more byte and a write finishes its current ACK.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy   <= 1'b0;
      gap    <= 4'h0;
      bytes  <= 4'h0;
      engSts <= '0;
    end else begin
      engSts.byteDone <= 1'b0;
      engSts.stopDone <= 1'b0;
      engSts.rdXfer   <= busy & rdMode;
      if (!busy) begin
        if (engCmd.start) begin
          busy  <= 1'b1;
          gap   <= 4'h0;
          bytes <= 4'h0;
        // The request is still seen while its STOP is being reported
        end else if (engCmd.stopReq && !engSts.stopDone) begin
          engSts.stopDone <= 1'b1;
        end
      end else if (gap == (slow ? 4'h7 : 4'h2)) begin
        gap             <= 4'h0;
        bytes           <= bytes + 4'h1;
        engSts.byteDone <= 1'b1;
        if (engCmd.stopReq || (bytes + 4'h1 == 4'(FRAME_BYTES))) begin
          busy            <= 1'b0;
          engSts.stopDone <= 1'b1;
        end
      end else begin
        gap <= gap + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* ssc_seq_ctrl_tb.sv */
// Self-checking bench of the sequence start/stop control.
// Assumes the engine model on the far side and the register port protocol.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_seq_ctrl_tb;
  localparam int FB = 4;
  logic                  clk_sys = 1'b0;
  logic                  rst_n;
  logic [3:0]            regAddr;
  logic [7:0]            regWdata;
  logic                  regWr;
  logic                  regRd;
  logic [7:0]            regRdata;
  logic                  trigPin;
  logic                  rdMode;
  logic                  slow;
  logic                  irq;
  ssc_pkg::ssc_eng_sts_t engSts;
  ssc_pkg::ssc_eng_cmd_t engCmd;
  logic [7:0]            nStart, nByte, nDone, nAfter, lastBytes, d;
  logic                  sawNack;
  int                    fail_count = 0;
  int                    compares = 0;

  always #5 clk_sys = ~clk_sys;

  ssc_seq_ctrl #(.TICK_CYC(4)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .trigPin(trigPin), .engSts(engSts),
    .engCmd(engCmd), .irq(irq));

  ssc_eng_model #(.FRAME_BYTES(FB)) u_eng (
    .clk_sys(clk_sys), .rst_n(rst_n), .engCmd(engCmd),
    .rdMode(rdMode), .slow(slow), .engSts(engSts));

  // ****************************************************************
  // Engine link monitor
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (engCmd.start) begin
      nStart = nStart + 8'h01;
      nByte  = 8'h00;
    end
    if (engSts.byteDone) begin
      nByte = nByte + 8'h01;
      if (engCmd.stopReq) nAfter = nAfter + 8'h01;
      if (engCmd.nackNext) sawNack = 1'b1;
    end
    if (engSts.stopDone) begin
      nDone     = nDone + 8'h01;
      lastBytes = nByte;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp,
                       input string what);
    rd(a);
    chk(what, d, exp);
  endtask

  task automatic clr();
    nStart  = 8'h00;
    nByte   = 8'h00;
    nDone   = 8'h00;
    nAfter  = 8'h00;
    sawNack = 1'b0;
  endtask

  // Bounded waits on the engine link counters
  task automatic waitStart(input logic [7:0] n);
    for (int i = 0; i < 2000 && nStart < n; i++) @(posedge clk_sys);
  endtask

  task automatic waitDone(input logic [7:0] n);
    for (int i = 0; i < 2000 && nDone < n; i++) @(posedge clk_sys);
    chk("stop count", nDone, n);
  endtask

  task automatic trig();
    @(posedge clk_sys);
    trigPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    trigPin <= 1'b0;
  endtask

  // Starts a run and writes a stop mid-frame
  task automatic runStop(input logic r, input logic [7:0] fc,
                         input logic [7:0] ctl);
    clr();
    rdMode <= r;
    slow   <= 1'b1;
    wr(`SSC_ADDR_FRAME_REPEAT_COUNT, fc);
    wr(`SSC_ADDR_CTRL, 8'h80);
    waitStart(8'h01);
    repeat (12) @(posedge clk_sys);
    wr(`SSC_ADDR_CTRL, ctl);
    waitDone(8'h01);
    repeat (60) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_n    = 1'b0;
    regAddr  = 4'h0;
    regWdata = 8'h00;
    regWr    = 1'b0;
    regRd    = 1'b0;
    trigPin  = 1'b0;
    rdMode   = 1'b0;
    slow     = 1'b0;
    clr();
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(`SSC_ADDR_FRAME_REPEAT_COUNT, `SSC_RST_FRAME_REPEAT_COUNT, "frame_repeat_count");
    rdChk(`SSC_ADDR_REFRESH_INTERVAL, `SSC_RST_REFRESH_INTERVAL, "refresh_interval");
    rdChk(`SSC_ADDR_INTMASK, `SSC_RST_INTMASK, "intmask");
    rdChk(4'hf, 8'h00, "unmapped");
    // Stop bits and trigger while idle change nothing
    wr(`SSC_ADDR_CTRL, 8'h60);
    rdChk(`SSC_ADDR_CTRL, 8'h00, "ctrl idle");
    trig();
    repeat (10) @(posedge clk_sys);
    chk("idle starts", nStart, 8'h00);
    rdChk(`SSC_ADDR_STATUS, 8'h00, "status idle");
    // Single shot; second start write while active is ignored.
    // A set mask bit lets its status bit through to irq.
    wr(`SSC_ADDR_INTMASK, 8'h80);
    wr(`SSC_ADDR_CTRL, 8'h80);
    waitStart(8'h01);
    wr(`SSC_ADDR_CTRL, 8'h80);
    waitDone(8'h01);
    repeat (4) @(posedge clk_sys);
    chk("single starts", nStart, 8'h01);
    chk("single bytes", lastBytes, 8'(FB));
    chk("irq set", {7'h0, irq}, 8'h01);
    rdChk(`SSC_ADDR_TRANSFERRED_BYTE_COUNT, 8'(FB), "transferred_byte_count");
    rdChk(`SSC_ADDR_STATUS, 8'h80, "status single");
    repeat (3) @(posedge clk_sys);
    chk("irq clear", {7'h0, irq}, 8'h00);
    wr(`SSC_ADDR_INTMASK, 8'h00);
    // Immediate stop on a read, stop-after-frame written beside it
    runStop(1'b1, 8'h01, 8'h60);
    chk("read extra", nAfter, 8'h01);
    chk("read nack", {7'h0, sawNack}, 8'h01);
    chk("read abort", {7'h0, lastBytes < 8'(FB)}, 8'h01);
    chk("masked irq", {7'h0, irq}, 8'h00);
    rdChk(`SSC_ADDR_TRANSFERRED_BYTE_COUNT, lastBytes, "transferred_byte_count read");
    rdChk(`SSC_ADDR_STATUS, 8'h80, "status read");
    // Immediate stop on a write
    runStop(1'b0, 8'h01, 8'h40);
    chk("write extra", nAfter, 8'h01);
    chk("write nack", {7'h0, sawNack}, 8'h00);
    rdChk(`SSC_ADDR_TRANSFERRED_BYTE_COUNT, lastBytes, "transferred_byte_count write");
    rdChk(`SSC_ADDR_STATUS, 8'h80, "status write");
    // Endless timer loop, immediate stop while transmitting
    wr(`SSC_ADDR_REFRESH_INTERVAL, 8'h08);
    runStop(1'b0, 8'h00, 8'h40);
    chk("loop stop starts", nStart, 8'h01);
    rdChk(`SSC_ADDR_STATUS, 8'hc0, "status loop stop");
    // Stop-after-frame while transmitting ends after the whole frame
    runStop(1'b0, 8'h00, 8'h20);
    chk("saf bytes", lastBytes, 8'(FB));
    chk("saf starts", nStart, 8'h01);
    rdChk(`SSC_ADDR_STATUS, 8'hc0, "status saf");
    // Counted timer loop; count write refused while running
    clr();
    wr(`SSC_ADDR_FRAME_REPEAT_COUNT, 8'h03);
    wr(`SSC_ADDR_CTRL, 8'h80);
    wr(`SSC_ADDR_FRAME_REPEAT_COUNT, 8'h05);
    rdChk(`SSC_ADDR_FRAME_REPEAT_COUNT, 8'h03, "frame_repeat_count locked");
    waitDone(8'h03);
    repeat (80) @(posedge clk_sys);
    chk("loop starts", nStart, 8'h03);
    rdChk(`SSC_ADDR_STATUS, 8'hc0, "status loop");
    // Stop while the timer loop sits between frames; the long period
    // keeps the loop idle well past the stop write
    clr();
    wr(`SSC_ADDR_REFRESH_INTERVAL, 8'h20);
    wr(`SSC_ADDR_FRAME_REPEAT_COUNT, 8'h00);
    wr(`SSC_ADDR_CTRL, 8'h80);
    waitDone(8'h01);
    wr(`SSC_ADDR_CTRL, 8'h20);
    rd(`SSC_ADDR_CTRL);
    chk("idle loop active", {7'h0, d[0]}, 8'h00);
    repeat (80) @(posedge clk_sys);
    chk("idle loop starts", nStart, 8'h01);
    rdChk(`SSC_ADDR_STATUS, 8'hc0, "status idle loop");
    // Trigger loop paces frames and ignores the count
    clr();
    slow <= 1'b0;
    wr(`SSC_ADDR_FRAME_REPEAT_COUNT, 8'h01);
    wr(`SSC_ADDR_CTRL, 8'h88);
    repeat (60) @(posedge clk_sys);
    chk("trig wait", nStart, 8'h00);
    trig();
    waitDone(8'h01);
    trig();
    waitDone(8'h02);
    rdChk(`SSC_ADDR_STATUS, 8'h00, "status trig run");
    wr(`SSC_ADDR_CTRL, 8'h20);
    repeat (6) @(posedge clk_sys);
    rdChk(`SSC_ADDR_STATUS, 8'hc0, "status trig saf");
    trig();
    repeat (30) @(posedge clk_sys);
    chk("trig after stop", nStart, 8'h02);
    // Immediate stop while a trigger frame is in flight
    clr();
    slow <= 1'b1;
    wr(`SSC_ADDR_CTRL, 8'h88);
    trig();
    waitStart(8'h01);
    wr(`SSC_ADDR_CTRL, 8'h40);
    rd(`SSC_ADDR_CTRL);
    chk("trig active", {7'h0, d[0]}, 8'h00);
    repeat (60) @(posedge clk_sys);
    rdChk(`SSC_ADDR_STATUS, 8'hc0, "status trig stop");
    finish_test();
  end
endmodule
`default_nettype wire
